// [include/adc_pwr_params.svh]
`ifndef ADC_PWR_PARAMS_SVH
`define ADC_PWR_PARAMS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_SETUP 4'h0
`define OFS_CONFIG 4'h1
`define OFS_STATUS 4'h2
`define OFS_RESULT0 4'h3
`define OFS_RESULT1 4'h4

// ************************************************************
// setup byte fields
// ************************************************************
`define SETUP_SEL_HI 6
`define SETUP_SEL_LO 4
`define SETUP_CLK_BIT 3
`define SETUP_BIP_BIT 2

// ************************************************************
// configuration byte fields
// ************************************************************
`define CFG_SCAN_HI 6
`define CFG_SCAN_LO 5
`define CFG_CS_BIT 1
`define CFG_SGL_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define SETUP_RESET 8'h00
`define CONFIG_RESET 8'h61

// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ 40
`define CONV_CYCLES 16'h0010

`endif

// [include/adc_pwr_pkg.sv]
package adc_pwr_pkg;
   // power controller states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CONVERT = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_STREAM = 4'b1000
   } pwr_state_t;

   // reference source
   typedef enum logic [1:0] {
      REF_SUPPLY = 2'h0,
      REF_EXTERNAL = 2'h1,
      REF_INTERNAL = 2'h2
   } ref_src_t;
endpackage

// [hdl/ref_decode.sv]
`include "adc_pwr_params.svh"

// ************************************************************
// reference select decoder
// ************************************************************
module ref_decode
   import adc_pwr_pkg::*;
(
   // select field
   input wire logic [2:0] sel_i,
   // decoded controls
   output ref_src_t src_o,
   output logic pin_drive_o,
   output logic keep_on_o
);
   // source, pin function and power from the field
   always_comb begin
      src_o = sel_i[2] ? REF_INTERNAL : (sel_i[1] ? REF_EXTERNAL : REF_SUPPLY);
      pin_drive_o = (sel_i[2:1] == 2'b11);
      keep_on_o = sel_i[2] & sel_i[0];
   end
endmodule

// [hdl/adc_pwr_ctrl.sv]
// Chosen here: the register addresses and the strobed register port.
`include "adc_pwr_params.svh"

// Notes on behaviour
// - reset selects single-ended unipolar input zero, internal clock, supply reference
// - result memory is not cleared at reset; contents undefined until written
// - idle shuts down all analog sections except internal reference kept on by select 1x1; here analog stays on while xfer_busy_i is high
// - external clock mode idles only after stop, nack or repeated start
// - internal clock mode powers down once all scan results are stored; here analog stays on while xfer_busy_i is high
// - internal mode results stay readable until next stop or repeated start
// - idle device watches for start plus own address
// - conversion circuitry powers up on valid address byte
// - supply or external reference wake-up adds no visible delay
// - three-bit select field sets source, pin function and reference power
// - select upper bits 11 drive internal reference onto pin
// - lowest select bit keeps reference on until reconfigured
// - results straight binary unipolar, two's complement bipolar
// - 00x supply, 01x external, 10x internal, 11x internal driven out
// - clock bit zero internal oscillator with stretching, one bus clock
module adc_pwr_ctrl
   import adc_pwr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // bus events from the serial front end
   input wire logic start_i,
   input wire logic addr_match_i,
   input wire logic stop_i,
   input wire logic nack_i,
   input wire logic xfer_busy_i,
   // converter core
   input wire logic [11:0] raw_i,
   input wire logic raw_valid_i,
   // power and control outputs
   output logic analog_on_o,
   output logic ref_on_o,
   output logic ref_pin_drive_o,
   output logic stretch_o,
   output logic conv_busy_o,
   output logic [1:0] ref_src_o
);

   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0] setup;
   logic [7:0] next_setup;
   logic [7:0] config_reg;
   logic [7:0] next_config;
   logic ref_latched;
   logic next_ref_latched;
   logic [11:0] result_mem [0:1];
   logic [15:0] next_rdata;
   pwr_state_t state;
   pwr_state_t next_state;
   logic [3:0] conv_left;
   logic [3:0] next_conv_left;
   logic wr_ptr;
   logic next_wr_ptr;
   logic results_valid;
   logic next_results_valid;
   logic [15:0] conv_cnt;
   logic [15:0] next_conv_cnt;

   // synchronised bus and converter events
   logic [5:0] ev_meta;
   logic [5:0] ev_sync;

   ref_src_t dec_src;
   logic dec_pin_drive;
   logic dec_keep_on;
   logic [11:0] coded;

   // ************************************************************
   // functions
   // ************************************************************
   // scan length from scan field and channel select
   function automatic logic [3:0] scan_len(input logic [7:0] cfg);
      logic [1:0] scan;
      scan = cfg[`CFG_SCAN_HI:`CFG_SCAN_LO];
      case (scan)
         2'b00: scan_len = cfg[`CFG_CS_BIT] ? 4'h2 : 4'h1;
         2'b01: scan_len = 4'h8;
         default: scan_len = 4'h1;
      endcase
   endfunction

   // coding of a raw result
   function automatic logic [11:0] code_result(input logic [11:0] raw, input logic bip);
      code_result = bip ? {~raw[11], raw[10:0]} : raw;
   endfunction

   // ************************************************************
   // input synchronisers
   // ************************************************************
   // two flops on every asynchronous event
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_meta <= 6'h00;
         ev_sync <= 6'h00;
      end else begin
         ev_meta <= {xfer_busy_i, nack_i, stop_i, addr_match_i, start_i, raw_valid_i};
         ev_sync <= ev_meta;
      end
   end

   logic raw_ok;
   logic addr_ok;
   logic stop_ok;
   logic nack_ok;
   logic busy_ok;
   logic start_ok;
   assign raw_ok = ev_sync[0];
   assign start_ok = ev_sync[1];
   assign addr_ok = ev_sync[2];
   assign stop_ok = ev_sync[3];
   assign nack_ok = ev_sync[4];
   assign busy_ok = ev_sync[5];

   // ************************************************************
   // reference decode
   // ************************************************************
   ref_decode u_ref_decode (
      .sel_i(setup[`SETUP_SEL_HI:`SETUP_SEL_LO]),
      .src_o(dec_src),
      .pin_drive_o(dec_pin_drive),
      .keep_on_o(dec_keep_on)
   );

   // ************************************************************
   // configuration registers
   // ************************************************************
   // register writes and reference power latch
   always_comb begin
      next_setup = setup;
      next_config = config_reg;
      next_ref_latched = ref_latched;
      if (wr_i && addr_i == `OFS_SETUP) begin
         next_setup = wdata_i;
         // new reference setting releases the latch
         if (wdata_i[`SETUP_SEL_HI:`SETUP_SEL_LO] != setup[`SETUP_SEL_HI:`SETUP_SEL_LO]) begin
            next_ref_latched = 1'b0;
         end
      end else if (dec_keep_on) begin
         next_ref_latched = 1'b1;
      end
      if (wr_i && addr_i == `OFS_CONFIG) begin
         next_config = wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setup <= `SETUP_RESET;
         config_reg <= `CONFIG_RESET;
         ref_latched <= 1'b0;
      end else begin
         setup <= next_setup;
         config_reg <= next_config;
         ref_latched <= next_ref_latched;
      end
   end

   // ************************************************************
   // power state machine
   // ************************************************************
   logic ext_clk;
   logic end_event;
   assign ext_clk = setup[`SETUP_CLK_BIT];
   assign end_event = stop_ok | nack_ok | start_ok;
   assign coded = code_result(raw_i, setup[`SETUP_BIP_BIT]);

   // next state, conversion count and write pointer
   always_comb begin
      next_state = state;
      next_conv_left = conv_left;
      next_wr_ptr = wr_ptr;
      next_results_valid = results_valid;
      next_conv_cnt = conv_cnt;
      case (state)
         ST_IDLE: begin
            if (addr_ok) begin
               // power up on our address, no wait for supply reference
               next_state = ext_clk ? ST_STREAM : ST_CONVERT;
               next_conv_left = scan_len(config_reg);
               next_wr_ptr = 1'b0;
               next_conv_cnt = 16'h0000;
            end else if (end_event) begin
               next_results_valid = 1'b0;
            end
         end
         ST_CONVERT: begin
            next_conv_cnt = conv_cnt + 16'h0001;
            if (raw_ok) begin
               next_wr_ptr = ~wr_ptr;
               next_conv_left = conv_left - 4'h1;
               if (conv_left == 4'h1) begin
                  // all results stored, shut down at once
                  next_state = ST_HOLD;
                  next_results_valid = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            // results kept through shutdown until stop or repeated start
            if (stop_ok || start_ok) begin
               next_results_valid = 1'b0;
               next_state = ST_IDLE;
            end else if (addr_ok) begin
               next_state = ST_CONVERT;
               next_conv_left = scan_len(config_reg);
               next_wr_ptr = 1'b0;
            end
         end
         ST_STREAM: begin
            if (raw_ok) begin
               next_wr_ptr = ~wr_ptr;
            end
            // idle only on stop, nack or repeated start, never mid-transfer
            if (end_event && !busy_ok) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         conv_left <= 4'h0;
         wr_ptr <= 1'b0;
         results_valid <= 1'b0;
         conv_cnt <= 16'h0000;
      end else begin
         state <= next_state;
         conv_left <= next_conv_left;
         wr_ptr <= next_wr_ptr;
         results_valid <= next_results_valid;
         conv_cnt <= next_conv_cnt;
      end
   end

   // ************************************************************
   // result memory
   // ************************************************************
   // no reset: contents undefined until first write
   always_ff @(posedge clk_i) begin
      if ((state == ST_CONVERT || state == ST_STREAM) && raw_ok) begin
         result_mem[wr_ptr] <= coded;
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   // read mux, data in the cycle after the strobe
   always_comb begin
      next_rdata = 16'h0000;
      if (rd_i) begin
         case (addr_i)
            `OFS_SETUP: next_rdata = {8'h00, setup};
            `OFS_CONFIG: next_rdata = {8'h00, config_reg};
            `OFS_STATUS: next_rdata = {8'h00, results_valid, ref_on_o, analog_on_o, state[3:0], 1'b0};
            `OFS_RESULT0: next_rdata = {4'h0, result_mem[0]};
            `OFS_RESULT1: next_rdata = {4'h0, result_mem[1]};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ************************************************************
   // power outputs
   // ************************************************************
   // analog on in convert or stream, or while a transfer is busy, reference by its own policy
   assign analog_on_o = (state == ST_CONVERT) || (state == ST_STREAM) || busy_ok;
   assign ref_on_o = (dec_src == REF_INTERNAL) && (ref_latched || analog_on_o);
   assign ref_pin_drive_o = dec_pin_drive && ref_on_o;
   assign stretch_o = (state == ST_CONVERT) && !ext_clk;
   assign conv_busy_o = (state == ST_CONVERT);
   assign ref_src_o = dec_src;
endmodule

// [sim/bus_master_model.sv]
// ****
// two-wire bus master, as seen through the front end
// ****
module bus_master_model #(
   parameter int WAKE = 8
) (
   // clock
   input wire logic clk_i,
   // bus events
   output logic start_o,
   output logic addr_match_o,
   output logic stop_o,
   output logic nack_o,
   output logic xfer_busy_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // all events quiet at start
   initial begin
      {start_o, addr_match_o, stop_o, nack_o, xfer_busy_o} = 5'h00;
   end

   // one-cycle pulse: 0 start, 1 address, 2 stop, 3 nack
   task automatic pulse(input int k);
      @(posedge clk_i);
      {nack_o, stop_o, addr_match_o, start_o} <= 4'h1 << k;
      @(posedge clk_i);
      {nack_o, stop_o, addr_match_o, start_o} <= 4'h0;
   endtask

   // start then own address
   task automatic address();
      pulse(0);
      pulse(1);
   endtask

   // end a transfer to let the device idle
   task automatic finish(input int k);
      pulse(k);
   endtask

   // wait for reference wake before converting
   task automatic ref_wake();
      repeat (WAKE) @(posedge clk_i);
   endtask

   // result transfer in progress
   task automatic busy(input logic b);
      @(posedge clk_i);
      xfer_busy_o <= b;
   endtask
endmodule

// [sim/adc_pwr_ctrl_assertions.sv]
`include "adc_pwr_params.svh"

// ****
// port checker
// ****
module adc_pwr_checker
   import adc_pwr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   // bus events
   input wire logic start_i,
   input wire logic addr_match_i,
   input wire logic stop_i,
   input wire logic nack_i,
   input wire logic xfer_busy_i,
   // converter core
   input wire logic [11:0] raw_i,
   input wire logic raw_valid_i,
   // power outputs
   input wire logic analog_on_o,
   input wire logic ref_on_o,
   input wire logic ref_pin_drive_o,
   input wire logic stretch_o,
   input wire logic conv_busy_o,
   input wire logic [1:0] ref_src_o
);
   logic [7:0] setup;
   logic [7:0] next_setup;
   logic [3:0] since_end;
   logic [3:0] next_since_end;

   // shadow setup byte, cycles since last end event
   always_comb begin
      next_setup = setup;
      if (wr_i && addr_i == `OFS_SETUP) next_setup = wdata_i;
      next_since_end = (since_end == 4'hf) ? since_end : since_end + 4'h1;
      if (stop_i || nack_i || start_i) next_since_end = 4'h0;
   end

   // register helpers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setup <= `SETUP_RESET;
         since_end <= 4'hf;
      end else begin
         setup <= next_setup;
         since_end <= next_since_end;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_pin;
      ref_pin_drive_o == ((setup[6:5] == 2'h3) && ref_on_o);
   endproperty
   a_pin: assert property (p_pin) else $error("pin drive wrong");
   property p_src;
      ref_src_o == (setup[6] ? 2'h2 : {1'b0, setup[5]});
   endproperty
   a_src: assert property (p_src) else $error("ref source wrong");
   property p_keep;
      setup[6] && setup[4] && ($past(setup[6:4]) == setup[6:4]) |-> ref_on_o;
   endproperty
   a_keep: assert property (p_keep) else $error("ref not kept on");
   property p_idle_rd;
      !$past(rd_i) |-> rdata_o == 16'h0000;
   endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("rdata without read");
   property p_unmapped;
      $past(rd_i) && $past(addr_i) > 4'h4 |-> rdata_o == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_setup_rd;
      $past(rd_i) && $past(addr_i) == `OFS_SETUP |-> rdata_o[6:2] == $past(setup[6:2]);
   endproperty
   a_setup_rd: assert property (p_setup_rd) else $error("setup readback");
   property p_busy_pwr;
      conv_busy_o |-> analog_on_o;
   endproperty
   a_busy_pwr: assert property (p_busy_pwr) else $error("convert unpowered");
   property p_wake;
      addr_match_i |-> ##[1:5] analog_on_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on address");
   property p_int_down;
      raw_valid_i && !setup[3] |-> ##[1:8] !analog_on_o;
   endproperty
   a_int_down: assert property (p_int_down) else $error("no shutdown");
   property p_ext_hold;
      $fell(analog_on_o) && setup[3] |-> since_end < 4'h8;
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("early shutdown");
   property p_stretch;
      stretch_o |-> !setup[3] && conv_busy_o;
   endproperty
   a_stretch: assert property (p_stretch) else $error("bad stretch");
endmodule

bind adc_pwr_ctrl adc_pwr_checker i_chk (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .start_i, .addr_match_i, .stop_i, .nack_i, .xfer_busy_i, .raw_i, .raw_valid_i,
   .analog_on_o, .ref_on_o, .ref_pin_drive_o, .stretch_o, .conv_busy_o, .ref_src_o);

// [sim/tb_top.sv]
`include "adc_pwr_params.svh"
`define chk(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, raw_valid_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic [11:0] raw_i = 12'h000;
   logic [15:0] rdata_o, d;
   logic [1:0] ref_src_o;
   logic st, am, sp, nk, xb, analog_on_o, ref_on_o, pin_o, stretch_o, conv_busy_o;
   int mismatches = 0, checks_done = 0;

   // ****
   // clock, dut, bus master
   // ****
   always #12.5 clk_i = ~clk_i;

   adc_pwr_ctrl i_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .start_i(st), .addr_match_i(am), .stop_i(sp), .nack_i(nk), .xfer_busy_i(xb), .raw_i,
      .raw_valid_i, .analog_on_o, .ref_on_o, .ref_pin_drive_o(pin_o), .stretch_o,
      .conv_busy_o, .ref_src_o);
   bus_master_model #(.WAKE(8)) i_bm (.clk_i, .start_o(st), .addr_match_o(am), .stop_o(sp),
      .nack_o(nk), .xfer_busy_o(xb));

   // register port cycles
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i);
      {addr_i, wdata_i, wr_i} <= {a, v, 1'b1};
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      {addr_i, rd_i} <= {a, 1'b1};
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // bounded wait for analog power level
   task automatic wait_pwr(input logic v);
      for (int n = 0; n < 20 && analog_on_o !== v; n++) @(posedge clk_i);
   endtask
   // converter core hands one result
   task automatic convert(input logic [11:0] r);
      for (int n = 0; n < 20 && conv_busy_o !== 1'b1; n++) @(posedge clk_i);
      @(posedge clk_i);
      {raw_i, raw_valid_i} <= {r, 1'b1};
      @(posedge clk_i);
      raw_valid_i <= 1'b0;
   endtask

   // ****
   // scenarios
   // ****
   task automatic t_reset();
      `chk("analog", 1'b0, analog_on_o)
      `chk("src", 2'h0, ref_src_o)
      rd(`OFS_SETUP);
      `chk("setup", 16'h0000, d)
      rd(`OFS_CONFIG);
      `chk("config", 16'h0061, d)
      rd(4'hf);
      `chk("unmapped", 16'h0000, d)
   endtask
   // keep-on latch takes one cycle after the select is written
   task automatic t_refsel();
      for (int s = 0; s < 8; s++) begin
         wr(`OFS_SETUP, {1'b0, s[2:0], 4'h0});
         @(posedge clk_i);
         #1;
         `chk("src", (s > 3) ? 2'h2 : 2'(s / 2), ref_src_o)
         `chk("pin", 1'(s == 7), pin_o)
         `chk("ref", 1'(s == 5 || s == 7), ref_on_o)
      end
      wr(`OFS_SETUP, 8'h50);
      i_bm.ref_wake();
      wr(`OFS_CONFIG, 8'h61);
      #1 `chk("ref kept", 1'b1, ref_on_o)
   endtask
   // reset again in mid-run restores the defaults
   task automatic t_rerun();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      #1 `chk("rst analog", 1'b0, analog_on_o)
      `chk("rst ref", 1'b0, ref_on_o)
      rd(`OFS_SETUP);
      `chk("rst setup", 16'h0000, d)
   endtask
   task automatic t_internal(input logic [7:0] su, input logic [11:0] r, input logic [15:0] e);
      wr(`OFS_SETUP, su);
      i_bm.address();
      wait_pwr(1'b1);
      `chk("wake", 1'b1, analog_on_o)
      `chk("stretch", 1'b1, stretch_o)
      `chk("busy", 1'b1, conv_busy_o)
      convert(r);
      wait_pwr(1'b0);
      `chk("down", 1'b0, analog_on_o)
      repeat (4) @(posedge clk_i);
      rd(`OFS_RESULT0);
      `chk("result", e, d)
      i_bm.finish(2);
   endtask
   task automatic t_external();
      wr(`OFS_SETUP, 8'h08);
      i_bm.address();
      convert(12'h3c1);
      repeat (10) @(posedge clk_i);
      #1 `chk("held", 1'b1, analog_on_o)
      `chk("no stretch", 1'b0, stretch_o)
      i_bm.busy(1'b1);
      i_bm.finish(2);
      repeat (8) @(posedge clk_i);
      #1 `chk("busy hold", 1'b1, analog_on_o)
      i_bm.busy(1'b0);
      i_bm.finish(3);
      wait_pwr(1'b0);
      `chk("ext down", 1'b0, analog_on_o)
   endtask

   // verdict
   task automatic conclude();
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_refsel();
      t_rerun();
      t_internal(8'h00, 12'h9a5, 16'h09a5);
      t_internal(8'h04, 12'h9a5, 16'h01a5);
      t_external();
      conclude();
   end

   // watchdog
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      conclude();
   end
endmodule
